// ### fer_pkg.sv
// shared constants, types and code-group decoding for the receive path
package fer_pkg;
    localparam int SMP_W = 6;
    localparam int NSYM = 5;
    localparam int CLK_PERIOD_NS = 40;
    localparam int IDLE_WIN_NS = 40000;
    localparam int IDLE_WIN_CYC = IDLE_WIN_NS / CLK_PERIOD_NS;
    localparam int LOCK_CYC = 6;
    localparam int IDLE_RUN = 10;
    localparam int PH_WIN = 64;
    localparam logic signed [5:0] SLICE_TH = 6'sh10;
    localparam logic [4:0] CG_IDLE = 5'h1F;
    localparam logic [4:0] CG_J = 5'h18;
    localparam logic [4:0] CG_K = 5'h11;
    localparam logic [4:0] CG_T = 5'h0D;
    localparam logic [4:0] CG_R = 5'h07;
    localparam logic [3:0] NIB_SSD = 4'h5;
    localparam logic [3:0] NIB_BAD_SSD = 4'hE;
    localparam logic [3:0] NIB_RST = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SSD2 = 3'b001,
        ST_DATA = 3'b010,
        ST_ESD2 = 3'b011,
        ST_IDL2 = 3'b100
    } fer_state_type;

    // returns {valid, nibble}
    function automatic logic [4:0] fer_dec5(input logic [4:0] cg);
        logic [4:0] r;
        r = 5'h00;
        unique case (cg)
            5'h1E: r = 5'h10;
            5'h09: r = 5'h11;
            5'h14: r = 5'h12;
            5'h15: r = 5'h13;
            5'h0A: r = 5'h14;
            5'h0B: r = 5'h15;
            5'h0E: r = 5'h16;
            5'h0F: r = 5'h17;
            5'h12: r = 5'h18;
            5'h13: r = 5'h19;
            5'h16: r = 5'h1A;
            5'h17: r = 5'h1B;
            5'h1A: r = 5'h1C;
            5'h1B: r = 5'h1D;
            5'h1C: r = 5'h1E;
            5'h1D: r = 5'h1F;
            default: r = 5'h00;
        endcase
        return r;
    endfunction
endpackage

// ### fer_frontend.sv
// sample slicing, sampling phase choice and three-level to bit decoding
`timescale 1ns/1ns
module fer_frontend
    import fer_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [29:0] smp_a_i,
    input wire logic [29:0] smp_b_i,
    output logic [4:0] bits_o,
    output logic phase_b_o
);
    logic signed [15:0] score_r;
    logic [6:0] win_cnt_r;
    logic [1:0] last_lvl_r;

    function automatic logic [1:0] slice(input logic signed [5:0] s);
        if (s > SLICE_TH) return 2'b01;
        if (s < -SLICE_TH) return 2'b11;
        return 2'b00;
    endfunction

    function automatic logic signed [7:0] margin(input logic signed [5:0] s);
        logic signed [7:0] a;
        a = (s < 0) ? -8'(s) : 8'(s);
        return (a >= 8'(SLICE_TH)) ? a - 8'(SLICE_TH) : 8'(SLICE_TH) - a;
    endfunction

    // margin comparison of the two phases over a window
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            score_r <= 16'sh0000;
            win_cnt_r <= 7'h00;
            phase_b_o <= 1'b0;
        end else begin
            logic signed [15:0] acc;
            acc = score_r;
            for (int i = 0; i < NSYM; i++) begin
                acc = acc + 16'(margin(smp_a_i[SMP_W*i +: SMP_W]))
                          - 16'(margin(smp_b_i[SMP_W*i +: SMP_W]));
            end
            if (win_cnt_r == 7'(PH_WIN - 1)) begin
                win_cnt_r <= 7'h00;
                score_r <= 16'sh0000;
                phase_b_o <= (acc < 0);
            end else begin
                win_cnt_r <= win_cnt_r + 7'h01;
                score_r <= acc;
            end
        end
    end

    // sample 4 is the earliest; a level change is a one
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bits_o <= 5'h00;
            last_lvl_r <= 2'b00;
        end else begin
            logic [1:0] prev;
            logic [1:0] cur;
            prev = last_lvl_r;
            for (int i = NSYM - 1; i >= 0; i--) begin
                cur = slice(phase_b_o ? smp_b_i[SMP_W*i +: SMP_W]
                                      : smp_a_i[SMP_W*i +: SMP_W]);
                bits_o[i] <= (cur != prev);
                prev = cur;
            end
            last_lvl_r <= prev;
        end
    end
endmodule

// ### fer_descram.sv
// descrambler with idle-based key lock and idle watchdog
`timescale 1ns/1ns
module fer_descram
    import fer_pkg::*;
#(
    parameter int IDLE_WIN = IDLE_WIN_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] bits_i,
    output logic [4:0] data_o,
    output logic locked_o,
    output logic abort_o
);
    // watchdog timer is sixteen bits wide
    if (IDLE_WIN < 2 || IDLE_WIN > 65535) begin : g_win_check
        $error("IDLE_WIN out of range");
    end

    logic [10:0] key_r;
    logic [2:0] match_r;
    logic [3:0] run_r;
    logic [15:0] idle_tmr_r;

    // returns {key, data, mismatch}
    function automatic logic [16:0] step(input logic [10:0] k, input logic [4:0] s,
                                         input logic lk);
        logic [4:0] o;
        logic mm;
        logic p;
        o = 5'h00;
        mm = 1'b0;
        for (int i = NSYM - 1; i >= 0; i--) begin
            p = k[10] ^ k[8];
            o[i] = s[i] ^ p;
            if (!s[i] != p) mm = 1'b1;
            k = {k[9:0], lk ? p : !s[i]};
        end
        return {k, o, mm};
    endfunction

    logic [16:0] st;
    assign st = step(key_r, bits_i, locked_o);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            key_r <= 11'h000;
            data_o <= 5'h00;
        end else begin
            key_r <= st[16:6];
            data_o <= st[5:1];
        end
    end

    // lock after a run of predicted idle ones, drop when idles vanish
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            locked_o <= 1'b0;
            match_r <= 3'h0;
            abort_o <= 1'b0;
            idle_tmr_r <= 16'h0000;
        end else begin
            abort_o <= 1'b0;
            if (!locked_o) begin
                match_r <= st[0] ? 3'h0 : match_r + 3'h1;
                idle_tmr_r <= 16'h0000;
                if (!st[0] && match_r == 3'(LOCK_CYC - 1)) locked_o <= 1'b1;
            end else if (run_r >= 4'(IDLE_RUN)) begin
                idle_tmr_r <= 16'h0000;
            end else if (idle_tmr_r == 16'(IDLE_WIN - 1)) begin
                locked_o <= 1'b0;
                abort_o <= 1'b1;
                match_r <= 3'h0;
                idle_tmr_r <= 16'h0000;
            end else begin
                idle_tmr_r <= idle_tmr_r + 16'h0001;
            end
        end
    end

    // trailing run of descrambled ones
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_r <= 4'h0;
        end else if (data_o == 5'h1F) begin
            run_r <= (run_r > 4'hA) ? 4'hF : run_r + 4'h5;
        end else begin
            run_r <= data_o[0] ? (data_o[1] ? (data_o[2] ? (data_o[3] ? 4'h4 : 4'h3)
                                 : 4'h2) : 4'h1) : 4'h0;
        end
    end
endmodule

// ### fer_rx_top.sv
// receive path top: input sync, alignment, code decoding and MII outputs
`timescale 1ns/1ns
// Function
// - six-bit line samples, five per clock, feed the front end
// - sampling phase with the larger slicing margin is chosen
// - three-level symbols become a bit stream before descrambling
// - descrambler inverts the scrambler and delivers five-bit groups
// - key syncs on idles, then holds and descrambles data
// - no idle within 40 us drops lock and aborts reception
// - J in the stream fixes group alignment until next frame
// - valid groups decode to nibbles on the receive data lines
// - start delimiter pair appears as two 0101 nibbles
// - data valid rises with the first start delimiter nibble
// - end delimiter or two idles end carrier and valid, not output
// - link failure or lost line signal ends valid at once
// - nibbles change on the receive clock while valid
// - unexpected group inside a frame raises receive error
// - bad start delimiter gives error with 1110, valid stays low
// - one nibble per 25 MHz clock, recovered from data
// - without line signal the clock source is the reference clock
// - J then K maps to 0101; out of order gives error
// - T then R ends frame; either alone gives error
// - invalid groups while valid raise receive error
// - a level change decodes as one, no change as zero
module fer_rx_top
    import fer_pkg::*;
#(
    parameter int IDLE_WIN = IDLE_WIN_CYC
) (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic [29:0] SMP_A_I,
    input wire logic [29:0] SMP_B_I,
    input wire logic LINE_SIGNAL_PRESENT_I,
    input wire logic LINK_FAIL_I,
    output logic [3:0] RXD_O,
    output logic RX_DV_O,
    output logic RX_ER_O,
    output logic CRS_O,
    output logic RXCLK_RECOV_O,
    output logic DESCR_LOCK_O
);
    // watchdog timer is sixteen bits wide
    if (IDLE_WIN < 2 || IDLE_WIN > 65535) begin : g_win_check
        $error("IDLE_WIN out of range");
    end

    logic [29:0] smp_a_s1_r;
    logic [29:0] smp_a_s2_r;
    logic [29:0] smp_b_s1_r;
    logic [29:0] smp_b_s2_r;
    logic [1:0] sig_s_r;
    logic [1:0] fail_s_r;
    logic [4:0] bits;
    logic phase_b;
    logic [4:0] dsc;
    logic locked;
    logic abort;
    logic [9:0] hist_r;
    logic [2:0] align_r;
    fer_state_type state_r;
    logic [3:0] d_nib_r;
    logic d_er_r;
    logic [4:0] code;
    logic [4:0] dec;
    logic j_hit;
    logic [2:0] j_off;
    logic active;

    // two-stage synchronisers for every input from outside except the reset
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            smp_a_s1_r <= 30'h0000_0000;
            smp_a_s2_r <= 30'h0000_0000;
            smp_b_s1_r <= 30'h0000_0000;
            smp_b_s2_r <= 30'h0000_0000;
            sig_s_r <= 2'b00;
            fail_s_r <= 2'b00;
        end else begin
            smp_a_s1_r <= SMP_A_I;
            smp_a_s2_r <= smp_a_s1_r;
            smp_b_s1_r <= SMP_B_I;
            smp_b_s2_r <= smp_b_s1_r;
            sig_s_r <= {sig_s_r[0], LINE_SIGNAL_PRESENT_I};
            fail_s_r <= {fail_s_r[0], LINK_FAIL_I};
        end
    end

    fer_frontend u_front (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .smp_a_i(smp_a_s2_r),
        .smp_b_i(smp_b_s2_r),
        .bits_o(bits),
        .phase_b_o(phase_b)
    );

    fer_descram #(
        .IDLE_WIN(IDLE_WIN)
    ) u_descr (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .bits_i(bits),
        .data_o(dsc),
        .locked_o(locked),
        .abort_o(abort)
    );

    // ten most recent descrambled bits, earliest in the msb
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            hist_r <= 10'h000;
        end else begin
            hist_r <= {hist_r[4:0], dsc};
        end
    end

    function automatic logic [4:0] window(input logic [9:0] h, input logic [2:0] o);
        logic [4:0] w;
        w = 5'h00;
        for (int i = 0; i < NSYM; i++) begin
            w[i] = h[int'(o) + i];
        end
        return w;
    endfunction

    // search every offset for the first start delimiter group
    always_comb begin
        j_hit = 1'b0;
        j_off = 3'h0;
        for (int o = NSYM - 1; o >= 0; o--) begin
            if (window(hist_r, 3'(o)) == CG_J) begin
                j_hit = 1'b1;
                j_off = 3'(o);
            end
        end
    end

    assign code = window(hist_r, align_r);
    assign dec = fer_dec5(code);
    assign active = locked && sig_s_r[1] && !fail_s_r[1] && !abort;

    // alignment is held until the next start delimiter
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            align_r <= 3'h0;
        end else if (state_r == ST_IDLE && j_hit) begin
            align_r <= j_off;
        end
    end

    // frame sequencing; outputs lag the groups by one so ends drop cleanly
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_r <= ST_IDLE;
            RXD_O <= NIB_RST;
            RX_DV_O <= 1'b0;
            RX_ER_O <= 1'b0;
            CRS_O <= 1'b0;
            d_nib_r <= NIB_RST;
            d_er_r <= 1'b0;
        end else if (!active) begin
            state_r <= ST_IDLE;
            RX_DV_O <= 1'b0;
            RX_ER_O <= 1'b0;
            CRS_O <= 1'b0;
        end else begin
            RX_ER_O <= 1'b0;
            unique case (state_r)
                ST_IDLE: begin
                    RX_DV_O <= 1'b0;
                    if (j_hit) begin
                        CRS_O <= 1'b1;
                        state_r <= ST_SSD2;
                    end
                end
                ST_SSD2: begin
                    if (code == CG_K) begin
                        RXD_O <= NIB_SSD;
                        RX_DV_O <= 1'b1;
                        d_nib_r <= NIB_SSD;
                        d_er_r <= 1'b0;
                        state_r <= ST_DATA;
                    end else begin
                        RXD_O <= NIB_BAD_SSD;
                        RX_ER_O <= 1'b1;
                        RX_DV_O <= 1'b0;
                        CRS_O <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
                ST_DATA: begin
                    RXD_O <= d_nib_r;
                    RX_DV_O <= 1'b1;
                    RX_ER_O <= d_er_r;
                    if (code == CG_T) begin
                        state_r <= ST_ESD2;
                    end else if (code == CG_IDLE) begin
                        state_r <= ST_IDL2;
                    end else begin
                        d_nib_r <= dec[4] ? dec[3:0] : code[3:0];
                        d_er_r <= !dec[4];
                    end
                end
                ST_ESD2, ST_IDL2: begin
                    if ((state_r == ST_ESD2 && code == CG_R) ||
                        (state_r == ST_IDL2 && code == CG_IDLE)) begin
                        RX_DV_O <= 1'b0;
                        CRS_O <= 1'b0;
                        state_r <= ST_IDLE;
                    end else begin
                        RX_DV_O <= 1'b1;
                        RX_ER_O <= 1'b1;
                        d_nib_r <= dec[4] ? dec[3:0] : code[3:0];
                        d_er_r <= !dec[4];
                        state_r <= ST_DATA;
                    end
                end
            endcase
        end
    end

    // clock source indication and lock status
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RXCLK_RECOV_O <= 1'b0;
            DESCR_LOCK_O <= 1'b0;
        end else begin
            RXCLK_RECOV_O <= sig_s_r[1] && locked;
            DESCR_LOCK_O <= locked;
        end
    end
endmodule

// ### fer_rx_monitor.sv
// concurrent checks on the receive path top ports
`timescale 1ns/1ns
module fer_rx_monitor
    import fer_pkg::*;
#(
    parameter int IDLE_WIN = IDLE_WIN_CYC
) (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic LINE_SIGNAL_PRESENT_I,
    input wire logic LINK_FAIL_I,
    input wire logic [3:0] RXD_O,
    input wire logic RX_DV_O,
    input wire logic RX_ER_O,
    input wire logic CRS_O,
    input wire logic RXCLK_RECOV_O,
    input wire logic DESCR_LOCK_O
);
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RST_N_I);
    sequence seq_ssd_pair;
        (RXD_O == NIB_SSD && !RX_ER_O) ##1 (RXD_O == NIB_SSD && RX_DV_O);
    endsequence
    sequence seq_dropped;
        !RX_DV_O && !CRS_O && !RX_ER_O;
    endsequence
    chk_dv_needs_crs: assert property (RX_DV_O |-> CRS_O)
        else $error("data valid without carrier");
    chk_ssd_pair: assert property ($rose(RX_DV_O) |-> seq_ssd_pair)
        else $error("frame did not open with two start nibbles");
    chk_crs_leads: assert property ($rose(RX_DV_O) |-> $past(CRS_O))
        else $error("carrier did not lead data valid");
    chk_bad_ssd_code: assert property (RX_ER_O && !RX_DV_O |-> RXD_O == NIB_BAD_SSD)
        else $error("error outside frame without 1110 code");
    chk_dv_end_crs: assert property ($fell(RX_DV_O) |-> !CRS_O)
        else $error("carrier stayed after data valid fell");
    chk_unlock_drop: assert property (!DESCR_LOCK_O |=> !RX_DV_O && !CRS_O)
        else $error("frame output while unlocked");
    chk_sig_loss: assert property (!LINE_SIGNAL_PRESENT_I |-> ##3 seq_dropped)
        else $error("frame kept after line signal loss");
    chk_link_fail: assert property (LINK_FAIL_I |-> ##3 !RX_DV_O)
        else $error("data valid kept after link failure");
    chk_clk_source: assert property (!LINE_SIGNAL_PRESENT_I |-> ##[2:3] !RXCLK_RECOV_O)
        else $error("clock source not reference without signal");
endmodule

// ### fer_line_model.sv
// far-end line model: scrambles code groups and sends three-level samples
`timescale 1ns/1ns
module fer_line_model
    import fer_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] cg_i,
    output logic [29:0] smp_a_o,
    output logic [29:0] smp_b_o
);
    logic [10:0] key_r;
    logic [1:0] lvl_r;
    logic [10:0] key_nxt;
    logic [1:0] lvl_nxt;
    logic [29:0] a_nxt;
    logic [29:0] b_nxt;
    logic kb;
    always_comb begin
        key_nxt = key_r;
        lvl_nxt = lvl_r;
        a_nxt = '0;
        b_nxt = '0;
        kb = 1'b0;
        for (int i = 4; i >= 0; i--) begin
            kb = key_nxt[10] ^ key_nxt[8];
            key_nxt = {key_nxt[9:0], kb};
            // level advances only on a one bit
            if (cg_i[i] ^ kb) begin
                lvl_nxt = lvl_nxt + 2'h1;
            end
            a_nxt[i*6 +: 6] = (lvl_nxt == 2'h1) ? 6'h18 : (lvl_nxt == 2'h3) ? 6'h28 : 6'h00;
            b_nxt[i*6 +: 6] = (lvl_nxt == 2'h1) ? 6'h12 : (lvl_nxt == 2'h3) ? 6'h2E : 6'h00;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            key_r <= 11'h5A5;
            lvl_r <= 2'h0;
            smp_a_o <= '0;
            smp_b_o <= '0;
        end else begin
            key_r <= key_nxt;
            lvl_r <= lvl_nxt;
            smp_a_o <= a_nxt;
            smp_b_o <= b_nxt;
        end
    end
endmodule

// ### tb.sv
// self-checking bench for the receive path top
`timescale 1ns/1ns
module tb;
    import fer_pkg::*;
    localparam int IDLE_WIN = 50;
    localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
        5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    localparam logic [4:0] CG_BAD = 5'h06;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sig = 1'b1;
    logic lfail = 1'b0;
    logic [4:0] cg = 5'h1F;
    logic [29:0] smp_a;
    logic [29:0] smp_b;
    logic [3:0] rxd;
    logic rx_dv, rx_er, crs, recov, lock;
    logic dv_d = 1'b0;
    logic [4:0] tx_q [$];
    logic [3:0] cap [$];
    int n_er = 0;
    int n_bad = 0;
    int n_rise = 0;
    int n_fail = 0;
    int tests_run = 0;
    always #20 clk = ~clk;
    fer_line_model i_fer_line_model (.clk_i(clk), .rst_n_i(rst_n), .cg_i(cg),
        .smp_a_o(smp_a), .smp_b_o(smp_b));
    fer_rx_top #(.IDLE_WIN(IDLE_WIN)) i_fer_rx_top (.MCLK_I(clk), .RST_N_I(rst_n),
        .SMP_A_I(smp_a), .SMP_B_I(smp_b), .LINE_SIGNAL_PRESENT_I(sig), .LINK_FAIL_I(lfail),
        .RXD_O(rxd), .RX_DV_O(rx_dv), .RX_ER_O(rx_er), .CRS_O(crs),
        .RXCLK_RECOV_O(recov), .DESCR_LOCK_O(lock));
    always @(posedge clk) begin
        cg <= (tx_q.size() > 0) ? tx_q.pop_front() : CG_IDLE;
        dv_d <= rx_dv;
        if (rx_dv === 1'b1) cap.push_back(rxd);
        if (rx_dv === 1'b1 && rx_er === 1'b1) n_er++;
        if (rx_dv === 1'b0 && rx_er === 1'b1 && rxd === NIB_BAD_SSD) n_bad++;
        if (rx_dv === 1'b1 && dv_d === 1'b0) n_rise++;
    end
    task close_out;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task wait_lock;
        int i;
        for (i = 0; i < 300; i++) begin
            if (lock === 1'b1) break;
            @(posedge clk);
        end
        if (i == 300) begin
            check("lock wait", 1, 0);
            close_out();
        end
    endtask
    task send(input logic [4:0] g [$]);
        cap.delete();
        n_er = 0;
        n_bad = 0;
        n_rise = 0;
        @(negedge clk);
        foreach (g[i]) tx_q.push_back(g[i]);
        for (int i = 0; i < 400 && tx_q.size() > 0; i++) @(posedge clk);
        if (tx_q.size() > 0) begin
            check("queue drain", 0, tx_q.size());
            close_out();
        end
        repeat (12) @(posedge clk);
        @(negedge clk);
    endtask
    task t_reset;
        repeat (10) @(posedge clk);
        check("reset outputs", 0, {rxd, rx_dv, rx_er, crs, recov, lock});
        rst_n <= 1'b1;
        wait_lock();
        repeat (4) @(posedge clk);
        @(negedge clk);
        check("clock source", 1, recov);
    endtask
    task t_frame_ok;
        logic [4:0] g [$];
        g = {CG_J, CG_K};
        for (int i = 0; i < 16; i++) g.push_back(ENC[i]);
        g = {g, CG_T, CG_R, CG_J, CG_K, ENC[3], CG_T, CG_R};
        send(g);
        check("nibble count", 21, cap.size());
        check("frame starts", 2, n_rise);
        check("start nibbles", {4'h5, 4'h5}, {cap[0], cap[1]});
        for (int i = 0; i < 16; i++) check("data nibble", i, cap[i + 2]);
        check("second frame nibble", 3, cap[20]);
        check("errors", 0, n_er);
        check("carrier after end", 0, crs);
    endtask
    task t_bad_ssd;
        send({CG_J, ENC[3], CG_IDLE});
        check("bad start code", 1, n_bad);
        check("nibbles after bad start", 0, cap.size());
    endtask
    task t_bad_code;
        send({CG_J, CG_K, ENC[1], CG_BAD, ENC[2], CG_T, ENC[3], CG_T, CG_R});
        check("nibble count", 7, cap.size());
        check("errors in frame", 2, n_er);
        check("data around errors", {4'h1, 4'h2, 4'h3}, {cap[2], cap[4], cap[6]});
    endtask
    task t_idle_end;
        send({CG_J, CG_K, ENC[6], CG_IDLE, ENC[7], CG_IDLE, CG_IDLE});
        check("nibble count", 5, cap.size());
        check("single idle error", 1, n_er);
        check("data after idle", 7, cap[4]);
        check("carrier after idles", 0, crs);
    endtask
    task t_drop(input bit by_link);
        cap.delete();
        @(negedge clk);
        tx_q = {CG_J, CG_K};
        for (int i = 0; i < 40; i++) tx_q.push_back(ENC[i % 16]);
        repeat (10) @(posedge clk);
        if (by_link) lfail <= 1'b1;
        else sig <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check("valid after drop", 0, rx_dv);
        check("start nibbles", 5, cap[0]);
        if (!by_link) check("clock source", 0, recov);
        @(posedge clk);
        lfail <= 1'b0;
        sig <= 1'b1;
        send({CG_IDLE});
        wait_lock();
    endtask
    task t_watchdog;
        int i;
        @(negedge clk);
        tx_q = {CG_J, CG_K};
        for (i = 0; i < 90; i++) tx_q.push_back(ENC[i % 16]);
        for (i = 0; i < 200; i++) begin
            @(posedge clk);
            if (lock === 1'b0) break;
        end
        if (i == 200) begin
            check("lock dropped", 0, 1);
            close_out();
        end
        repeat (2) @(negedge clk);
        check("valid after abort", 0, {rx_dv, crs});
        send({CG_IDLE});
        wait_lock();
    endtask
    initial begin
        t_reset();
        t_frame_ok();
        t_bad_ssd();
        t_bad_code();
        t_idle_end();
        t_drop(1'b0);
        t_drop(1'b1);
        t_watchdog();
        close_out();
    end
endmodule
bind fer_rx_top fer_rx_monitor #(.IDLE_WIN(IDLE_WIN)) i_fer_rx_monitor (.MCLK_I(MCLK_I),
    .RST_N_I(RST_N_I), .LINE_SIGNAL_PRESENT_I(LINE_SIGNAL_PRESENT_I),
    .LINK_FAIL_I(LINK_FAIL_I), .RXD_O(RXD_O), .RX_DV_O(RX_DV_O), .RX_ER_O(RX_ER_O),
    .CRS_O(CRS_O), .RXCLK_RECOV_O(RXCLK_RECOV_O), .DESCR_LOCK_O(DESCR_LOCK_O));
